// file: design/pmic_supply_sequencer.sv
// Digital sequencer and fault logic of a three-output supply device
`timescale 1ns/1ps
module pmic_supply_sequencer #(
  parameter bit SEQ_PART = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        enablePin,
  input  wire logic        overheat,
  input  wire logic        lowSupply,
  input  wire logic        brownout,
  input  wire logic [6:0]  buckLevel,
  input  wire logic [6:0]  lin1Level,
  input  wire logic [6:0]  lin2Level,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             buckDrive,
  output logic             lin1Drive,
  output logic             lin2Drive,
  output logic             biasOn,
  output logic      [7:0]  buckVolt,
  output logic      [7:0]  lin1Volt,
  output logic      [7:0]  lin2Volt,
  output logic             faultIrqOut,
  output logic             faultIrqOe
);

  // Brownout and pin reset merged
  logic rstAll;
  assign rstAll = !nrst || brownout;

  // Enable pin synchroniser and edge detect
  logic enS1_r, enS2_r, enS3_r;
  logic enS1_nxt, enS2_nxt, enS3_nxt;
  logic firstCyc_r, firstCyc_nxt;
  logic enRise, enFall;
  always_comb begin
    enS1_nxt     = enablePin;
    enS2_nxt     = enS1_r;
    enS3_nxt     = enS2_r;
    firstCyc_nxt = 1'b0;
  end
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      enS1_r     <= 1'b0;
      enS2_r     <= 1'b0;
      enS3_r     <= 1'b0;
      firstCyc_r <= 1'b1;
    end else begin
      enS1_r     <= enS1_nxt;
      enS2_r     <= enS2_nxt;
      enS3_r     <= enS3_nxt;
      firstCyc_r <= firstCyc_nxt;
    end
  end
  assign enRise = enS2_r && !enS3_r;
  assign enFall = !enS2_r && enS3_r && !firstCyc_r;

  // Fault condition and its end
  logic faultNow, faultWas_r, faultWas_nxt, faultEnd;
  assign faultNow = overheat || lowSupply;
  assign faultEnd = faultWas_r && !faultNow;

  // Bus handshake
  logic acc, wr;
  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign pready = 1'b1;

  // Control registers
  logic [2:0] supEn_r, supEn_nxt;
  logic       ordOff_r, ordOff_nxt;
  logic       raf_r, raf_nxt;
  logic       ien_r, ien_nxt;
  logic       heat_r, heat_nxt, low_r, low_nxt;
  logic [7:0] bv_r, bv_nxt, l1v_r, l1v_nxt, l2v_r, l2v_nxt;
  logic       bias_r, bias_nxt;
  logic [2:0] defEn;
  assign defEn = SEQ_PART ? pmic_seq_pkg::SEQ_DEFAULT : pmic_seq_pkg::NOSEQ_DEFAULT;

  // Next value of register state
  always_comb begin
    supEn_nxt    = supEn_r;
    ordOff_nxt   = ordOff_r;
    raf_nxt      = raf_r;
    ien_nxt      = ien_r;
    heat_nxt     = heat_r;
    low_nxt      = low_r;
    bv_nxt       = bv_r;
    l1v_nxt      = l1v_r;
    l2v_nxt      = l2v_r;
    bias_nxt     = bias_r;
    faultWas_nxt = faultNow;
    // Host writes
    if (wr) begin
      case (paddr)
        pmic_seq_pkg::ADDR_ENABLE: begin
          supEn_nxt  = pwdata[2:0];
          ordOff_nxt = SEQ_PART ? pwdata[pmic_seq_pkg::EN_ORD] : 1'b0;
          raf_nxt    = pwdata[pmic_seq_pkg::EN_RAF];
          if (pwdata[2:0] != 3'h0) begin
            bias_nxt = 1'b1;
          end
        end
        pmic_seq_pkg::ADDR_STATUS: begin
          ien_nxt = pwdata[pmic_seq_pkg::ST_IEN];
          if (pwdata[pmic_seq_pkg::ST_HEAT]) begin
            heat_nxt = 1'b0;
          end
          if (pwdata[pmic_seq_pkg::ST_LOW]) begin
            low_nxt = 1'b0;
          end
        end
        pmic_seq_pkg::ADDR_BUCKV: bv_nxt  = pwdata[7:0];
        pmic_seq_pkg::ADDR_LIN1V: l1v_nxt = pwdata[7:0];
        pmic_seq_pkg::ADDR_LIN2V: l2v_nxt = pwdata[7:0];
        default: ;
      endcase
      // Register shutdown keeps bias off, so a later pin fall does nothing
      if (paddr == pmic_seq_pkg::ADDR_ENABLE && pwdata[2:0] == 3'h0) begin
        bias_nxt = 1'b0;
      end
    end
    // Enable pin edges
    if (enFall && bias_r) begin
      supEn_nxt = 3'h0;
      bias_nxt  = 1'b0;
    end
    // Default startup on rise, or on fault end with restart allowed
    if (enRise || (faultEnd && raf_r)) begin
      bv_nxt     = pmic_seq_pkg::BUCKV_DEF;
      l1v_nxt    = pmic_seq_pkg::LIN1V_DEF;
      l2v_nxt    = pmic_seq_pkg::LIN2V_DEF;
      ordOff_nxt = 1'b0;
      raf_nxt    = enRise ? 1'b1 : raf_r;
      supEn_nxt  = defEn;
      bias_nxt   = 1'b1;
    end
    // Fault: reload defaults, bias as it was, restart bit untouched
    // Enables only reload when a restart will follow, so outputs stay off otherwise
    if (faultNow) begin
      supEn_nxt  = raf_r ? defEn : 3'h0;
      bv_nxt     = pmic_seq_pkg::BUCKV_DEF;
      l1v_nxt    = pmic_seq_pkg::LIN1V_DEF;
      l2v_nxt    = pmic_seq_pkg::LIN2V_DEF;
      ordOff_nxt = 1'b0;
    end
    // Flags set wins over write-one clear
    if (overheat) begin
      heat_nxt = 1'b1;
    end
    if (lowSupply) begin
      low_nxt = 1'b1;
    end
  end

  // Register update; brownout acts as power-on reset
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      supEn_r    <= 3'h0;
      ordOff_r   <= 1'b0;
      raf_r      <= 1'b1;
      ien_r      <= 1'b0;
      heat_r     <= 1'b0;
      low_r      <= 1'b0;
      bv_r       <= pmic_seq_pkg::BUCKV_DEF;
      l1v_r      <= pmic_seq_pkg::LIN1V_DEF;
      l2v_r      <= pmic_seq_pkg::LIN2V_DEF;
      bias_r     <= 1'b0;
      faultWas_r <= 1'b0;
    end else begin
      supEn_r    <= supEn_nxt;
      ordOff_r   <= ordOff_nxt;
      raf_r      <= raf_nxt;
      ien_r      <= ien_nxt;
      heat_r     <= heat_nxt;
      low_r      <= low_nxt;
      bv_r       <= bv_nxt;
      l1v_r      <= l1v_nxt;
      l2v_r      <= l2v_nxt;
      bias_r     <= bias_nxt;
      faultWas_r <= faultWas_nxt;
    end
  end

  // Power-good flags with hysteresis, one per output
  logic [2:0] good_r, good_nxt;
  logic [6:0] lvl [3];
  assign lvl[0] = buckLevel;
  assign lvl[1] = lin1Level;
  assign lvl[2] = lin2Level;
  logic [2:0] drv;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_good
      always_comb begin
        good_nxt[gi] = good_r[gi];
        if (!drv[gi] || lvl[gi] <= pmic_seq_pkg::GOOD_CLR_PCT) begin
          good_nxt[gi] = 1'b0;
        end else if (lvl[gi] >= pmic_seq_pkg::GOOD_SET_PCT) begin
          good_nxt[gi] = 1'b1;
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      good_r <= 3'h0;
    end else begin
      good_r <= good_nxt;
    end
  end

  // Output drive: chained through power-good when ordering is active
  logic chain;
  assign chain = SEQ_PART && !ordOff_r;
  always_comb begin
    drv = 3'h0;
    if (!faultNow && bias_r) begin
      drv[0] = supEn_r[0];
      drv[1] = supEn_r[1] && (!chain || !supEn_r[0] || good_r[0]);
      drv[2] = supEn_r[2] && (!chain || !(supEn_r[1] || (supEn_r[0] && !supEn_r[1]))
               || (supEn_r[1] ? good_r[1] : good_r[0]));
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk) begin
    if (rstAll) begin
      buckDrive <= 1'b0;
      lin1Drive <= 1'b0;
      lin2Drive <= 1'b0;
      biasOn    <= 1'b0;
      buckVolt  <= pmic_seq_pkg::BUCKV_DEF;
      lin1Volt  <= pmic_seq_pkg::LIN1V_DEF;
      lin2Volt  <= pmic_seq_pkg::LIN2V_DEF;
    end else begin
      buckDrive <= drv[0];
      lin1Drive <= drv[1];
      lin2Drive <= drv[2];
      biasOn    <= bias_r;
      buckVolt  <= bv_r;
      lin1Volt  <= l1v_r;
      lin2Volt  <= l2v_r;
    end
  end

  // Open-drain interrupt: drives low only
  assign faultIrqOut = 1'b0;
  assign faultIrqOe  = ien_r && (heat_r || low_r);

  // Read mux
  always_comb begin
    prdata  = 32'h0;
    pslverr = 1'b0;
    case (paddr)
      pmic_seq_pkg::ADDR_ENABLE: prdata = {26'h0, raf_r, ordOff_r, 1'b0, supEn_r};
      pmic_seq_pkg::ADDR_STATUS: prdata = {25'h0, ien_r, low_r, heat_r, 1'b0, good_r};
      pmic_seq_pkg::ADDR_BUCKV:  prdata = {24'h0, bv_r};
      pmic_seq_pkg::ADDR_LIN1V:  prdata = {24'h0, l1v_r};
      pmic_seq_pkg::ADDR_LIN2V:  prdata = {24'h0, l2v_r};
      pmic_seq_pkg::ADDR_GOOD:   prdata = {29'h0, buckDrive ? 1'b0 : 1'b0, 2'h0};
      default:                   pslverr = acc;
    endcase
  end

endmodule

// file: design/pmic_seq_pkg.sv
// Package of constants for the supply sequencer
// Contract
// - Power-on loads every register default
// - Startup at power-on if enable high
// - Default startup reloads settings, then sequences
// - No-sequence variant: ordering bit zero, one supply
// - Enable rising edge starts default startup
// - Enable falling edge: all off, bias off
// - Falling edge ignored after register shutdown
// - Supplies follow bits, chained in order
// - Voltage write applies at bus acknowledge; the register takes it then, and buckVolt follows one clock later
// - Fault: outputs off, flag set, defaults reload
// - Fault end restarts only if restart bit
// - Fault flags clear only by reset or write-one
// - Brownout returns device to power-on state
// - Power-good sets 90%, clears 85%
// - Interrupt low while allowed and flag set
// - Write-one releases interrupt unless fault persists
// - Interrupt allow bit defaults to zero
// - Each power-good enables the next supply
// - Order: buck, first linear, second linear
// - Flag clears by write-one, resets if fault persists
package pmic_seq_pkg;
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BUCKV  = 8'h08;
  localparam logic [7:0] ADDR_LIN1V  = 8'h0c;
  localparam logic [7:0] ADDR_LIN2V  = 8'h10;
  localparam logic [7:0] ADDR_GOOD   = 8'h14;
  // Enable register field positions
  localparam int EN_BUCK = 0;
  localparam int EN_LIN1 = 1;
  localparam int EN_LIN2 = 2;
  localparam int EN_ORD  = 4;
  localparam int EN_RAF  = 5;
  // Status register field positions
  localparam int ST_HEAT = 4;
  localparam int ST_LOW  = 5;
  localparam int ST_IEN  = 6;
  // Power-on defaults
  localparam logic [7:0] ENABLE_POR   = 8'h20;
  localparam logic [2:0] SEQ_DEFAULT  = 3'h7;
  localparam logic [2:0] NOSEQ_DEFAULT = 3'h1;
  localparam logic [7:0] BUCKV_DEF    = 8'h10;
  localparam logic [7:0] LIN1V_DEF    = 8'h14;
  localparam logic [7:0] LIN2V_DEF    = 8'h14;
  // Power-good thresholds, percent of target
  localparam logic [6:0] GOOD_SET_PCT = 7'd90;
  localparam logic [6:0] GOOD_CLR_PCT = 7'd85;
endpackage

// file: dv/reg_out_model.sv
// Ramp model of one regulator output level
`timescale 1ns/1ps
module reg_out_model (
  input  logic       ref_clk,
  input  logic       drive,
  output logic [6:0] level
);
  initial level = 7'h00;
  // Rise while driven, decay once released
  always @(posedge ref_clk) begin
    if (drive) level <= (level > 7'h55) ? 7'h64 : level + 7'h0f;
    else level <= (level < 7'h0f) ? 7'h00 : level - 7'h0f;
  end
endmodule

// file: dv/pmic_seq_assertions.sv
// Port checker for the supply sequencer
`timescale 1ns/1ps
module pmic_seq_checker (
  input logic       ref_clk,
  input logic       nrst,
  input logic       enablePin,
  input logic       overheat,
  input logic       brownout,
  input logic [6:0] buckLevel,
  input logic [6:0] lin1Level,
  input logic       psel,
  input logic       penable,
  input logic [7:0] paddr,
  input logic       pready,
  input logic       pslverr,
  input logic       buckDrive,
  input logic       lin1Drive,
  input logic       lin2Drive,
  input logic       biasOn,
  input logic       faultIrqOut,
  input logic       faultIrqOe,
  input logic [7:0] buckVolt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst || brownout);
  // Bus answer and refusal
  a_pready_now:
    assert property (psel && penable |-> pready) else $error("pready low");
  a_unmapped_err:
    assert property (psel && penable && paddr >= 8'h18 |-> pslverr) else $error("no slave error");
  // Faults, chain and pin edges
  a_fault_off:
    assert property (overheat |-> ##[1:3] !(buckDrive || lin1Drive || lin2Drive)) else $error("fault left on");
  a_bias_kept:
    assert property (overheat && biasOn && enablePin |=> biasOn) else $error("bias lost");
  a_lin1_chain:
    assert property ($rose(lin1Drive) && buckDrive |-> buckLevel >= pmic_seq_pkg::GOOD_SET_PCT) else $error("lin1 early");
  a_lin2_chain:
    assert property ($rose(lin2Drive) && lin1Drive |-> lin1Level >= pmic_seq_pkg::GOOD_SET_PCT) else $error("lin2 early");
  a_rise_starts:
    assert property ($rose(enablePin) && !overheat |-> ##[1:6] buckDrive) else $error("no startup");
  a_fall_stops:
    assert property ($fell(enablePin) |-> ##[1:8] !(buckDrive || lin1Drive || lin2Drive)) else $error("no shutdown");
  a_irq_pin_low:
    assert property (faultIrqOe |-> !faultIrqOut) else $error("irq pin high");
  a_brownout_clears:
    assert property (@(posedge ref_clk) disable iff (!nrst)
      brownout |=> !buckDrive && !biasOn && !faultIrqOe && buckVolt == pmic_seq_pkg::BUCKV_DEF) else $error("brownout");
  cover property (buckDrive && lin1Drive && lin2Drive);
  cover property (faultIrqOe);
  cover property (psel && penable && pslverr);
endmodule
bind pmic_supply_sequencer pmic_seq_checker i_chk (
  .ref_clk(ref_clk), .nrst(nrst), .enablePin(enablePin), .overheat(overheat), .brownout(brownout),
  .buckLevel(buckLevel), .lin1Level(lin1Level), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .buckDrive(buckDrive), .lin1Drive(lin1Drive), .lin2Drive(lin2Drive),
  .biasOn(biasOn), .faultIrqOut(faultIrqOut), .faultIrqOe(faultIrqOe), .buckVolt(buckVolt)
);

// file: dv/pmic_supply_sequencer_tb_top.sv
// Testbench for the supply sequencer over APB
`timescale 1ns/1ps
module pmic_supply_sequencer_tb_top;
  logic        ref_clk = 1'b0, nrst = 1'b0, enablePin = 1'b0, overheat = 1'b0, lowSupply = 1'b0;
  logic        brownout = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [6:0]  buckLevel, lin1Level, lin2Level;
  logic [7:0]  buckVolt;
  logic        pready, pslverr, buckDrive, lin1Drive, lin2Drive, biasOn, faultIrqOut, faultIrqOe;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;
  pmic_supply_sequencer i_dut (.ref_clk(ref_clk), .nrst(nrst), .enablePin(enablePin), .overheat(overheat),
    .lowSupply(lowSupply), .brownout(brownout), .buckLevel(buckLevel), .lin1Level(lin1Level),
    .lin2Level(lin2Level), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .buckDrive(buckDrive), .lin1Drive(lin1Drive),
    .lin2Drive(lin2Drive), .biasOn(biasOn), .buckVolt(buckVolt), .lin1Volt(), .lin2Volt(),
    .faultIrqOut(faultIrqOut), .faultIrqOe(faultIrqOe));
  reg_out_model i_buck (.ref_clk(ref_clk), .drive(buckDrive), .level(buckLevel));
  reg_out_model i_lin1 (.ref_clk(ref_clk), .drive(lin1Drive), .level(lin1Level));
  reg_out_model i_lin2 (.ref_clk(ref_clk), .drive(lin2Drive), .level(lin2Level));
  always #12.5 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_mismatch++;
      close_out();
    end
  end
  task close_out();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // One APB transfer; holds the request until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task drv(input logic [2:0] e);
    int i;
    for (i = 0; i < 60 && {lin2Drive, lin1Drive, buckDrive} !== e; i++) @(posedge ref_clk);
    chk({29'h0, lin2Drive, lin1Drive, buckDrive}, {29'h0, e});
  endtask
  // Main sequence; pin and bus never act together, no partial startups
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(pmic_seq_pkg::ADDR_ENABLE, 32'hffffffff, 32'h20);
    rd(pmic_seq_pkg::ADDR_STATUS, 32'hffffffff, 32'h0);
    enablePin <= 1'b1;
    drv(3'h1);
    drv(3'h3);
    drv(3'h7);
    rd(pmic_seq_pkg::ADDR_ENABLE, 32'hffffffff, 32'h27);
    apb(1'b1, pmic_seq_pkg::ADDR_BUCKV, 32'h33);
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({24'h0, buckVolt}, 32'h33);
    apb(1'b1, pmic_seq_pkg::ADDR_STATUS, 32'h40);
    overheat <= 1'b1;
    drv(3'h0);
    chb(biasOn, 1'b1);
    rd(pmic_seq_pkg::ADDR_STATUS, 32'hf0, 32'h50);
    chb(faultIrqOe, 1'b1);
    chk({24'h0, buckVolt}, 32'h10);
    apb(1'b1, pmic_seq_pkg::ADDR_STATUS, 32'h50);
    rd(pmic_seq_pkg::ADDR_STATUS, 32'hf0, 32'h50);
    overheat <= 1'b0;
    drv(3'h1);
    rd(pmic_seq_pkg::ADDR_STATUS, 32'hf0, 32'h50);
    apb(1'b1, pmic_seq_pkg::ADDR_STATUS, 32'h50);
    @(negedge ref_clk);
    chb(faultIrqOe, 1'b0);
    apb(1'b1, pmic_seq_pkg::ADDR_ENABLE, 32'h0);
    drv(3'h0);
    lowSupply <= 1'b1;
    repeat (4) @(posedge ref_clk);
    lowSupply <= 1'b0;
    repeat (30) @(posedge ref_clk);
    drv(3'h0);
    rd(pmic_seq_pkg::ADDR_STATUS, 32'hf0, 32'h60);
    enablePin <= 1'b0;
    repeat (10) @(posedge ref_clk);
    drv(3'h0);
    enablePin <= 1'b1;
    drv(3'h7);
    enablePin <= 1'b0;
    drv(3'h0);
    repeat (4) @(posedge ref_clk);
    chb(biasOn, 1'b0);
    rd(pmic_seq_pkg::ADDR_ENABLE, 32'hffffffff, 32'h20);
    apb(1'b0, 8'h18, 32'h0);
    chb(err, 1'b1);
    brownout <= 1'b1;
    @(posedge ref_clk);
    brownout <= 1'b0;
    rd(pmic_seq_pkg::ADDR_STATUS, 32'hffffffff, 32'h0);
    close_out();
  end
endmodule
